// ---- verilog/xfer_pkg.sv ----
// constants and carrier types for the transfer and ram-address executor
package xfer_pkg;

	// instruction word width and opcodes of the transfer group
	localparam int INSTR_W = 10;
	localparam logic [9:0] OPC_COPY_B_TO_ACC = 10'h01E;
	localparam logic [9:0] OPC_COPY_ACC_TO_AUX = 10'h00E;
	localparam logic [9:0] OPC_READ_COLUMN = 10'h01F;
	localparam logic [9:0] OPC_WRITE_COLUMN = 10'h00C;
	localparam logic [9:0] OPC_PACK_PAIR = 10'h01A;
	localparam logic [9:0] OPC_UNPACK_WIDE = 10'h02A;
	localparam logic [9:0] OPC_SET_ROM_PTR = 10'h029;
	localparam logic [9:0] OPC_READ_ROM_PTR = 10'h051;
	localparam logic [9:0] OPC_READ_BANK = 10'h053;
	localparam logic [9:0] OPC_COPY_FILE = 10'h052;
	localparam logic [9:0] OPC_READ_STACK = 10'h050;
	localparam logic [9:0] OPC_INC_COLUMN = 10'h013;
	localparam logic [9:0] OPC_DEC_COLUMN = 10'h017;

	// opcode families with an immediate field: match on the upper bits
	localparam logic [1:0] OPH_LOAD_FILE_COL = 2'h3;
	localparam logic [7:0] OPH_LOAD_BANK = 8'h12;
	localparam logic [5:0] OPH_LOAD_ACC_RAM = 6'h2C;
	localparam logic [5:0] OPH_SWAP = 6'h2D;
	localparam logic [5:0] OPH_SWAP_INC = 6'h2E;
	localparam logic [5:0] OPH_SWAP_DEC = 6'h2F;
	localparam logic [5:0] OPH_STORE = 6'h2B;

	// field positions inside the instruction word
	localparam int IMM_FILE_MSB = 7;
	localparam int IMM_FILE_LSB = 4;
	localparam int IMM_COL_MSB = 3;
	localparam int IMM_LOW_LSB = 0;

	// column values that trigger a skip after inc or dec, and the step of one used by inc and dec
	localparam logic [3:0] COL_WRAP_UP = 4'h0;
	localparam logic [3:0] COL_WRAP_DOWN = 4'hF;
	localparam logic [3:0] NIBBLE_ONE = 4'h1;

	typedef enum logic [4:0] {
		OP_NONE, OP_COPY_B_TO_ACC, OP_COPY_ACC_TO_AUX, OP_READ_COLUMN,
		OP_WRITE_COLUMN, OP_PACK, OP_UNPACK, OP_SET_ROM, OP_READ_ROM,
		OP_READ_BANK, OP_COPY_FILE, OP_READ_STACK, OP_LOAD_FILE_COL,
		OP_LOAD_BANK, OP_INC_COL, OP_DEC_COL, OP_LOAD_ACC, OP_SWAP,
		OP_SWAP_INC, OP_SWAP_DEC, OP_STORE
	} op_type;

	// cpu registers touched by this group
	typedef struct packed {
		logic [3:0] acc;
		logic [3:0] aux;
		logic [7:0] wide;
		logic [2:0] romPtr;
		logic [3:0] file;
		logic [3:0] col;
		logic [1:0] bank;
	} regs_type;

	// whole state of the executor
	typedef struct packed {
		regs_type regs;
		logic skip;
		logic lxyChain;
	} state_type;

	// data ram access: address is bank, file, column
	typedef struct packed {
		logic [9:0] addr;
		logic we;
		logic [3:0] wrData;
	} ram_type;

	localparam state_type STATE_RESET = '0;

endpackage

// ---- verilog/xfer_exec.sv ----
// executor for register transfer, ram address and ram transfer instructions
// How it works
// RULE_01: 01E copies aux into acc; 00E copies acc into aux.
// RULE_02: 01F copies column into acc; 00C copies acc into column.
// RULE_03: pack puts aux in wide high nibble, acc in low nibble.
// RULE_04: 02A unpacks wide: high nibble to aux, low to acc.
// RULE_05: 029 loads rom pointer from acc bits 2 to 0.
// RULE_06: 051 copies rom pointer into acc low bits, bit 3 zero.
// RULE_07: 053 copies bank into acc bits 1..0, bits 3..2 zero.
// RULE_08: 052 copies file register into acc unchanged.
// RULE_09: 050 copies stack depth into acc low bits, bit 3 zero.
// RULE_10: load file and column immediates; repeats after the first skipped.
// RULE_11: 048 plus z loads the two-bit bank immediate.
// RULE_12: 013 increments column modulo 16, skips next when result 0.
// RULE_13: 017 decrements column modulo 16, skips next when result 15.
// RULE_14: load acc from ram at pointer, then file ^= j.
// RULE_15: swap acc with ram at pointer, then file ^= j, no skip.
// RULE_16: swap and xor, then decrement column, skip when it becomes 15.
// RULE_17: swap and xor, then increment column, skip when it becomes 0.
// RULE_18: store acc into ram at pointer, then file ^= j.
// RULE_19: a skipped instruction is fetched but has no side effects; a skipped file/column load still sets lxyChain, suppressing a following one.
`timescale 1ns/1ns

module xfer_exec (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic instrValid,
	input wire logic [9:0] instr,
	input wire logic [2:0] stackDepth,
	input wire logic [3:0] ramRdData,
	output xfer_pkg::regs_type regs,
	output xfer_pkg::ram_type ram,
	output logic skipPending,
	output logic suppressed
);

	xfer_pkg::state_type s_r;
	xfer_pkg::state_type s_nxt;
	xfer_pkg::op_type op;
	logic exec;
	logic [3:0] imm;
	logic [3:0] colUp;
	logic [3:0] colDown;
	logic [3:0] immHigh;
	logic [1:0] immBank;

	////////////////////////////////////////////////////////////////////
	// decode of the instruction word into an operation class
	function automatic xfer_pkg::op_type decode(input logic [9:0] w);
		xfer_pkg::op_type o;
		o = xfer_pkg::OP_NONE;
		if (w[9:8] == xfer_pkg::OPH_LOAD_FILE_COL) begin
			o = xfer_pkg::OP_LOAD_FILE_COL;
		end else if (w[9:2] == xfer_pkg::OPH_LOAD_BANK) begin
			o = xfer_pkg::OP_LOAD_BANK;
		end else begin
			unique case (w[9:4])
				xfer_pkg::OPH_LOAD_ACC_RAM: o = xfer_pkg::OP_LOAD_ACC;
				xfer_pkg::OPH_SWAP: o = xfer_pkg::OP_SWAP;
				xfer_pkg::OPH_SWAP_INC: o = xfer_pkg::OP_SWAP_INC;
				xfer_pkg::OPH_SWAP_DEC: o = xfer_pkg::OP_SWAP_DEC;
				xfer_pkg::OPH_STORE: o = xfer_pkg::OP_STORE;
				default: o = xfer_pkg::OP_NONE;
			endcase
			unique case (w)
				xfer_pkg::OPC_COPY_B_TO_ACC: o = xfer_pkg::OP_COPY_B_TO_ACC;
				xfer_pkg::OPC_COPY_ACC_TO_AUX: o = xfer_pkg::OP_COPY_ACC_TO_AUX;
				xfer_pkg::OPC_READ_COLUMN: o = xfer_pkg::OP_READ_COLUMN;
				xfer_pkg::OPC_WRITE_COLUMN: o = xfer_pkg::OP_WRITE_COLUMN;
				xfer_pkg::OPC_PACK_PAIR: o = xfer_pkg::OP_PACK;
				xfer_pkg::OPC_UNPACK_WIDE: o = xfer_pkg::OP_UNPACK;
				xfer_pkg::OPC_SET_ROM_PTR: o = xfer_pkg::OP_SET_ROM;
				xfer_pkg::OPC_READ_ROM_PTR: o = xfer_pkg::OP_READ_ROM;
				xfer_pkg::OPC_READ_BANK: o = xfer_pkg::OP_READ_BANK;
				xfer_pkg::OPC_COPY_FILE: o = xfer_pkg::OP_COPY_FILE;
				xfer_pkg::OPC_READ_STACK: o = xfer_pkg::OP_READ_STACK;
				xfer_pkg::OPC_INC_COLUMN: o = xfer_pkg::OP_INC_COL;
				xfer_pkg::OPC_DEC_COLUMN: o = xfer_pkg::OP_DEC_COL;
				default: ;
			endcase
		end
		return o;
	endfunction

	////////////////////////////////////////////////////////////////////
	// operands shared by several operations
	assign op = decode(instr);
	assign imm = instr[xfer_pkg::IMM_COL_MSB:xfer_pkg::IMM_LOW_LSB];
	assign immHigh = instr[xfer_pkg::IMM_FILE_MSB:xfer_pkg::IMM_FILE_LSB];
	assign immBank = instr[1:0];
	assign colUp = s_r.regs.col + xfer_pkg::NIBBLE_ONE;
	assign colDown = s_r.regs.col - xfer_pkg::NIBBLE_ONE;

	// a pending skip or a repeated file/column load kills the instruction
	assign suppressed = instrValid && (s_r.skip ||
		(op == xfer_pkg::OP_LOAD_FILE_COL && s_r.lxyChain)); // [RULE_10] [RULE_19]
	assign exec = instrValid && !suppressed;

	// ram faces the current pointer; write data is the acc flop
	assign ram.addr = {s_r.regs.bank, s_r.regs.file, s_r.regs.col};
	assign ram.wrData = s_r.regs.acc;
	assign ram.we = exec && (op == xfer_pkg::OP_SWAP ||
		op == xfer_pkg::OP_SWAP_INC || op == xfer_pkg::OP_SWAP_DEC ||
		op == xfer_pkg::OP_STORE); // [RULE_15] [RULE_18] [RULE_19]
	assign regs = s_r.regs;
	assign skipPending = s_r.skip;

	////////////////////////////////////////////////////////////////////
	// next state: one instruction per valid cycle
	always_comb begin
		s_nxt = s_r;
		if (instrValid) begin
			s_nxt.skip = 1'b0; // a skip lasts for exactly one instruction
			s_nxt.lxyChain = (op == xfer_pkg::OP_LOAD_FILE_COL); // [RULE_10]
		end
		if (exec) begin
			unique case (op)
				xfer_pkg::OP_COPY_B_TO_ACC: s_nxt.regs.acc = s_r.regs.aux; // [RULE_01]
				xfer_pkg::OP_COPY_ACC_TO_AUX: s_nxt.regs.aux = s_r.regs.acc; // [RULE_01]
				xfer_pkg::OP_READ_COLUMN: s_nxt.regs.acc = s_r.regs.col; // [RULE_02]
				xfer_pkg::OP_WRITE_COLUMN: s_nxt.regs.col = s_r.regs.acc; // [RULE_02]
				xfer_pkg::OP_PACK: begin
					s_nxt.regs.wide = {s_r.regs.aux, s_r.regs.acc}; // [RULE_03]
				end
				xfer_pkg::OP_UNPACK: begin
					s_nxt.regs.aux = s_r.regs.wide[7:4]; // [RULE_04]
					s_nxt.regs.acc = s_r.regs.wide[3:0]; // [RULE_04]
				end
				xfer_pkg::OP_SET_ROM: s_nxt.regs.romPtr = s_r.regs.acc[2:0]; // [RULE_05]
				xfer_pkg::OP_READ_ROM: begin
					s_nxt.regs.acc = {1'b0, s_r.regs.romPtr}; // [RULE_06]
				end
				xfer_pkg::OP_READ_BANK: begin
					s_nxt.regs.acc = {2'b00, s_r.regs.bank}; // [RULE_07]
				end
				xfer_pkg::OP_COPY_FILE: s_nxt.regs.acc = s_r.regs.file; // [RULE_08]
				xfer_pkg::OP_READ_STACK: s_nxt.regs.acc = {1'b0, stackDepth}; // [RULE_09]
				xfer_pkg::OP_LOAD_FILE_COL: begin
					s_nxt.regs.file = immHigh; // [RULE_10]
					s_nxt.regs.col = imm; // [RULE_10]
				end
				xfer_pkg::OP_LOAD_BANK: s_nxt.regs.bank = immBank; // [RULE_11]
				xfer_pkg::OP_INC_COL: begin
					s_nxt.regs.col = colUp; // [RULE_12]
					s_nxt.skip = (colUp == xfer_pkg::COL_WRAP_UP); // [RULE_12]
				end
				xfer_pkg::OP_DEC_COL: begin
					s_nxt.regs.col = colDown; // [RULE_13]
					s_nxt.skip = (colDown == xfer_pkg::COL_WRAP_DOWN); // [RULE_13]
				end
				xfer_pkg::OP_LOAD_ACC: begin
					s_nxt.regs.acc = ramRdData; // [RULE_14]
					s_nxt.regs.file = s_r.regs.file ^ imm; // [RULE_14]
				end
				xfer_pkg::OP_SWAP: begin
					s_nxt.regs.acc = ramRdData; // [RULE_15]
					s_nxt.regs.file = s_r.regs.file ^ imm; // [RULE_15]
				end
				xfer_pkg::OP_SWAP_INC: begin
					s_nxt.regs.acc = ramRdData; // [RULE_17]
					s_nxt.regs.file = s_r.regs.file ^ imm; // [RULE_17]
					s_nxt.regs.col = colUp; // [RULE_17]
					s_nxt.skip = (colUp == xfer_pkg::COL_WRAP_UP); // [RULE_17]
				end
				xfer_pkg::OP_SWAP_DEC: begin
					s_nxt.regs.acc = ramRdData; // [RULE_16]
					s_nxt.regs.file = s_r.regs.file ^ imm; // [RULE_16]
					s_nxt.regs.col = colDown; // [RULE_16]
					s_nxt.skip = (colDown == xfer_pkg::COL_WRAP_DOWN); // [RULE_16]
				end
				xfer_pkg::OP_STORE: begin
					s_nxt.regs.file = s_r.regs.file ^ imm; // [RULE_18]
				end
				xfer_pkg::OP_NONE: ; // other groups are handled elsewhere
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= xfer_pkg::STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks of the executed behaviour
	sequence incExec_s;
		exec && (op == xfer_pkg::OP_INC_COL || op == xfer_pkg::OP_SWAP_INC);
	endsequence

	sequence decExec_s;
		exec && (op == xfer_pkg::OP_DEC_COL || op == xfer_pkg::OP_SWAP_DEC);
	endsequence

	sequence swapExec_s;
		exec && (op == xfer_pkg::OP_SWAP || op == xfer_pkg::OP_SWAP_INC ||
			op == xfer_pkg::OP_SWAP_DEC);
	endsequence

	aux_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		exec && op == xfer_pkg::OP_COPY_B_TO_ACC
		|=> regs.acc == $past(regs.aux))
		else $error("acc did not take aux");

	column_write_a: assert property (@(posedge clk) // [RULE_02]
		disable iff (!rst_n)
		exec && op == xfer_pkg::OP_WRITE_COLUMN
		|=> regs.col == $past(regs.acc) && regs.acc == $past(regs.acc))
		else $error("column write wrong");

	wide_pack_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		exec && op == xfer_pkg::OP_PACK
		|=> regs.wide == {$past(regs.aux), $past(regs.acc)})
		else $error("pack order wrong");

	wide_unpack_a: assert property (@(posedge clk) // [RULE_04]
		disable iff (!rst_n)
		exec && op == xfer_pkg::OP_UNPACK
		|=> {regs.aux, regs.acc} == $past(regs.wide))
		else $error("unpack order wrong");

	rom_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
		exec && op == xfer_pkg::OP_READ_ROM
		|=> regs.acc[3] == 1'b0 && regs.acc[2:0] == $past(regs.romPtr))
		else $error("rom pointer read wrong");

	bank_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
		exec && op == xfer_pkg::OP_READ_BANK
		|=> regs.acc == {2'b00, $past(regs.bank)})
		else $error("bank read wrong");

	stack_read_a: assert property (@(posedge clk) // [RULE_09]
		disable iff (!rst_n)
		exec && op == xfer_pkg::OP_READ_STACK
		|=> regs.acc == {1'b0, $past(stackDepth)})
		else $error("stack depth read wrong");

	load_chain_a: assert property (@(posedge clk) // [RULE_10]
		disable iff (!rst_n)
		instrValid && op == xfer_pkg::OP_LOAD_FILE_COL
		##1 instrValid && op == xfer_pkg::OP_LOAD_FILE_COL
		|-> suppressed ##1 $stable(regs.file) && $stable(regs.col))
		else $error("repeated file load executed");

	inc_skip_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
		incExec_s |=> regs.col == $past(regs.col) + xfer_pkg::NIBBLE_ONE
		&& skipPending == (regs.col == xfer_pkg::COL_WRAP_UP))
		else $error("column increment or skip wrong");

	dec_skip_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
		decExec_s |=> regs.col == $past(regs.col) - xfer_pkg::NIBBLE_ONE
		&& skipPending == (regs.col == xfer_pkg::COL_WRAP_DOWN))
		else $error("column decrement or skip wrong");

	swap_xor_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
		swapExec_s |-> ram.we && ram.wrData == regs.acc
		##1 regs.acc == $past(ramRdData)
		&& regs.file == ($past(regs.file) ^ $past(imm)))
		else $error("swap or file xor wrong");

	skip_quiet_a: assert property (@(posedge clk) // [RULE_19]
		disable iff (!rst_n)
		instrValid && skipPending |-> !ram.we ##1 $stable(regs) && !skipPending)
		else $error("skipped instruction had effect");

	// pointer and immediate loads, and the file copy to acc, land in the right register
	rom_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
		exec && op == xfer_pkg::OP_SET_ROM
		|=> {1'b0, regs.romPtr} == ($past(regs.acc) & 4'h7))
		else $error("rom pointer load wrong");

	file_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
		exec && op == xfer_pkg::OP_COPY_FILE
		|=> regs.acc == $past(regs.file))
		else $error("file copy to acc wrong");

	file_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
		exec && op == xfer_pkg::OP_LOAD_FILE_COL
		|=> regs.file == $past(immHigh) && regs.col == $past(imm))
		else $error("file and column load wrong");

	bank_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
		exec && op == xfer_pkg::OP_LOAD_BANK
		|=> regs.bank == $past(immBank))
		else $error("bank immediate load wrong");

	// ram load reads only; store writes the acc and keeps it
	ram_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
		exec && op == xfer_pkg::OP_LOAD_ACC |-> !ram.we
		##1 regs.acc == $past(ramRdData)
		&& regs.file == ($past(regs.file) ^ $past(imm)))
		else $error("ram load or file xor wrong");

	ram_store_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_18]
		exec && op == xfer_pkg::OP_STORE |-> ram.we
		##1 regs.acc == $past(regs.acc)
		&& regs.file == ($past(regs.file) ^ $past(imm)))
		else $error("ram store or file xor wrong");

endmodule

// ---- tb/data_ram_model.sv ----
// behavioural data ram facing the executor's memory port
`timescale 1ns/1ns

module data_ram_model (
	input wire logic clk,
	input wire xfer_pkg::ram_type ram,
	output logic [3:0] rdData
);
	logic [3:0] mem [1024];

	////////////////////////////////////////////////////////////////////////
	// known fill so that the first reads are defined
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 4'(i ^ (i >> 4));
		end
	end

	// read follows the pointer in the same cycle
	assign rdData = mem[ram.addr];

	// write lands on the rising edge while the strobe is high
	always @(posedge clk) begin
		if (ram.we) begin
			mem[ram.addr] <= ram.wrData;
		end
	end
endmodule

// ---- tb/cpu_register_ram_transfer_ops_tb_top.sv ----
// self-checking bench for the transfer and ram-address executor
`timescale 1ns/1ns

module cpu_register_ram_transfer_ops_tb_top;
	logic clk;
	logic rst_n;
	logic instrValid;
	logic [9:0] instr;
	logic [2:0] stackDepth;
	logic [3:0] ramRdData;
	xfer_pkg::regs_type regs;
	xfer_pkg::ram_type ram;
	logic skipPending;
	logic suppressed;
	int err_total;
	int comparisons;
	int seed;
	logic [3:0] mAcc, mAux, mFile, mCol, t;
	logic [7:0] mWide;
	logic [2:0] mRom;
	logic [1:0] mBank;
	logic mSkip, mChain;
	logic [3:0] refMem [1024];
	logic [9:0] ops [21] = '{10'h01E, 10'h00E, 10'h01F, 10'h00C, 10'h01A,
		10'h02A, 10'h029, 10'h051, 10'h053, 10'h052, 10'h050, 10'h013,
		10'h017, 10'h300, 10'h048, 10'h2B0, 10'h2C0, 10'h2D0, 10'h2E0,
		10'h2F0, 10'h000};
	logic [9:0] corner [13] = '{10'h000, 10'h35F, 10'h3A0, 10'h013,
		10'h01F, 10'h017, 10'h2F3, 10'h2E0, 10'h2B1, 10'h2F2, 10'h01E,
		10'h312, 10'h04B};

	xfer_exec uut (
		.clk(clk),
		.rst_n(rst_n),
		.instrValid(instrValid),
		.instr(instr),
		.stackDepth(stackDepth),
		.ramRdData(ramRdData),
		.regs(regs),
		.ram(ram),
		.skipPending(skipPending),
		.suppressed(suppressed)
	);

	data_ram_model ram_far (
		.clk(clk),
		.ram(ram),
		.rdData(ramRdData)
	);

	////////////////////////////////////////////////////////////////////////
	// result comparison and verdict
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// reference model of the executor
	function automatic logic supFor(input logic v, input logic [9:0] i);
		return v && (mSkip || (i[9:8] == 2'h3 && mChain));
	endfunction

	function automatic logic wrFor(input logic v, input logic [9:0] i);
		return v && !supFor(v, i) && i[9:8] == 2'h2 && i[7:4] >= 4'hB &&
			i[7:4] != 4'hC;
	endfunction

	task automatic resetModel();
		{mAcc, mAux, mWide, mRom, mFile, mCol, mBank} = '0;
		mSkip = 1'b0;
		mChain = 1'b0;
	endtask

	task automatic checkOuts(input logic v, input logic [9:0] i);
		logic [9:0] a;
		a = {mBank, mFile, mCol};
		chk("acc", 16'(mAcc), 16'(regs.acc));
		chk("aux", 16'(mAux), 16'(regs.aux));
		chk("wide", 16'(mWide), 16'(regs.wide));
		chk("romPtr", 16'(mRom), 16'(regs.romPtr));
		chk("file", 16'(mFile), 16'(regs.file));
		chk("col", 16'(mCol), 16'(regs.col));
		chk("bank", 16'(mBank), 16'(regs.bank));
		chk("skipPending", 16'(mSkip), 16'(skipPending));
		chk("suppressed", 16'(supFor(v, i)), 16'(suppressed));
		chk("ram", 16'({a, wrFor(v, i), mAcc}), 16'(ram));
	endtask

	// drive one cycle, check mid-cycle, then advance the model at the edge
	task automatic step(input logic v, input logic [9:0] i);
		logic sup;
		logic [9:0] a;
		instrValid <= v;
		instr <= i;
		stackDepth <= 3'($random(seed));
		#50;
		checkOuts(v, i);
		sup = supFor(v, i);
		a = {mBank, mFile, mCol};
		@(posedge clk);
		if (v) begin
			mSkip = 1'b0;
			mChain = (i[9:8] == 2'h3);
		end
		if (v && !sup) begin
			t = refMem[a];
			if (wrFor(v, i)) begin
				refMem[a] = mAcc;
			end
			if (i[9:6] == 4'hB) begin
				mAcc = t;
			end
			if (i[9:8] == 2'h2 && i[7:4] >= 4'hB) begin
				mFile = mFile ^ i[3:0];
			end
			casez (i)
				10'h01E: mAcc = mAux;
				10'h00E: mAux = mAcc;
				10'h01F: mAcc = mCol;
				10'h00C: mCol = mAcc;
				10'h01A: mWide = {mAux, mAcc};
				10'h02A: {mAux, mAcc} = mWide;
				10'h029: mRom = mAcc[2:0];
				10'h051: mAcc = {1'b0, mRom};
				10'h053: mAcc = {2'b00, mBank};
				10'h052: mAcc = mFile;
				10'h050: mAcc = {1'b0, stackDepth};
				10'h3??: {mFile, mCol} = i[7:0];
				10'b00_0100_10??: mBank = i[1:0];
				10'h013, 10'h2E?: begin
					mCol = mCol + 4'h1;
					mSkip = (mCol == 4'h0);
				end
				10'h017, 10'h2F?: begin
					mCol = mCol - 4'h1;
					mSkip = (mCol == 4'hF);
				end
				default: ;
			endcase
		end
	endtask

	task automatic randStep();
		int k;
		logic [9:0] m;
		k = {$random(seed)} % 21;
		m = (k < 13) ? 10'h000 : (k == 13) ? 10'h0FF : (k == 14) ? 10'h003 :
			(k == 20) ? 10'h3FF : 10'h00F;
		step(($random(seed) % 8) != 0, ops[k] | (10'($random(seed)) & m));
	endtask

	////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// watchdog
	initial begin
		#1_000_000;
		err_total++;
		final_report();
	end

	// main sequence
	initial begin
		seed = 19577;
		err_total = 0;
		comparisons = 0;
		rst_n = 1'b0;
		instrValid = 1'b0;
		instr = 10'h000;
		stackDepth = 3'h0;
		for (int i = 0; i < 1024; i++) begin
			refMem[i] = 4'(i ^ (i >> 4));
		end
		resetModel();
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			step(1'b1, ops[k] | ((k > 12) ? 10'h001 : 10'h000));
		end
		foreach (corner[k]) begin
			step(1'b1, corner[k]);
		end
		repeat (2000) randStep();
		rst_n <= 1'b0;
		instrValid <= 1'b0;
		#50;
		resetModel();
		checkOuts(1'b0, 10'h000);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (50) randStep();
		final_report();
	end
endmodule
